// ### core/sns_pkg.sv
// Purpose: shared constants for the subtract and nibble swap datapath
// Assumes: one core clock, four phases make one instruction cycle
// Notes: opcode field values follow the 14-bit instruction encoding
package sns_pkg;
	// ****************************************
	// widths and phases
	// ****************************************
	localparam int unsigned SNS_DATA_W = 8; // datapath width
	localparam int unsigned SNS_ADDR_W = 7; // file register address width
	localparam int unsigned SNS_INSN_W = 14; // instruction word width
	localparam int unsigned SNS_PHASES = 4; // phases per instruction cycle

	// ****************************************
	// opcode fields
	// ****************************************
	localparam logic [3:0] SNS_OP_SUB_REG = 4'h2; // bits 11:8 for reg subtract
	localparam logic [3:0] SNS_OP_SWAP = 4'he; // bits 11:8 for nibble swap
	localparam logic [1:0] SNS_GRP_REG = 2'h0; // bits 13:12 register group
	localparam logic [1:0] SNS_GRP_LIT = 2'h3; // bits 13:12 literal group
	localparam logic [2:0] SNS_OP_SUB_LIT = 3'h6; // bits 11:9 literal subtract
	localparam int unsigned SNS_DEST_BIT = 7; // destination select bit
	localparam logic [7:0] SNS_W_RESET = 8'h00; // accumulator reset value

	// operation decoded in the first phase
	typedef enum logic [1:0] {
		SNS_NONE,
		SNS_SUBLIT,
		SNS_SUBREG,
		SNS_SWAP
	} sns_op_e;

	// phase sequence of one instruction cycle
	typedef enum logic [1:0] {
		SNS_PH_DECODE,
		SNS_PH_READ,
		SNS_PH_PROCESS,
		SNS_PH_WRITE
	} sns_phase_e;
endpackage : sns_pkg

// ### core/sns_subtractor.sv
// Purpose: 8-bit subtract with inverted-borrow carry and digit carry
// Assumes: pure combinational, used inside one phase
// Notes: result is minuend minus subtrahend, wrapped to 8 bits
module sns_subtractor
	import sns_pkg::*;
(
	// operands
	input wire logic [SNS_DATA_W-1:0] minuend,
	input wire logic [SNS_DATA_W-1:0] subtrahend,
	// results
	output logic [SNS_DATA_W-1:0] diff,
	output logic carry_no_borrow,
	output logic digit_carry
);
	// ****************************************
	// arithmetic
	// ****************************************
	logic [SNS_DATA_W:0] full_sum; // minuend plus complement plus one
	logic [4:0] low_sum; // low nibble sum for digit carry

	// two's complement add; the top bit is the inverted borrow
	always_comb begin
		full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
		low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
		diff = full_sum[SNS_DATA_W-1:0];
		carry_no_borrow = full_sum[SNS_DATA_W];
		digit_carry = low_sum[4];
	end
endmodule : sns_subtractor

// ### core/sns_datapath.sv
// Purpose: execute literal subtract, register subtract and nibble swap
// Assumes: insn valid in the decode phase, ignored in the other three phases
// Notes: other opcodes leave accumulator, flags and registers alone
//
// What this block does
// - swap exchanges register nibbles, flags untouched
// - swap destination zero writes accumulator only
// - swap destination one writes register back
// - literal subtract: decode, read, process, write phases
// - positive difference sets carry to one
// - zero difference also sets carry to one
// - negative difference clears carry, keeps wrapped result
// - literal subtract computes literal minus accumulator
// - literal subtract writes accumulator, updates three flags
module sns_datapath
	import sns_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// instruction in
	input wire logic [SNS_INSN_W-1:0] insn,
	// file register read port
	output logic [SNS_ADDR_W-1:0] reg_addr,
	input wire logic [SNS_DATA_W-1:0] reg_rdata,
	// file register write port
	output logic reg_we,
	output logic [SNS_DATA_W-1:0] reg_wdata,
	// architectural state
	output logic [SNS_DATA_W-1:0] acc_q,
	output logic carry_flag,
	output logic digit_carry_flag,
	output logic zero_flag,
	// phase indication
	output logic cycle_start
);
	// ****************************************
	// phase sequencer
	// ****************************************
	sns_phase_e phase_q; // current phase
	sns_op_e op_q; // op latched at decode
	logic dest_q; // destination bit latched at decode
	logic [SNS_DATA_W-1:0] lit_q; // literal latched at decode
	logic [SNS_ADDR_W-1:0] addr_q; // register address latched at decode
	logic [SNS_DATA_W-1:0] opnd_q; // operand read in second phase
	logic [SNS_DATA_W-1:0] res_q; // result computed in third phase
	logic c_q; // carry computed in third phase
	logic dc_q; // digit carry computed in third phase
	logic c_flag_q; // carry flag
	logic dc_flag_q; // digit carry flag
	logic z_flag_q; // zero flag
	logic we_q; // register write strobe
	logic [SNS_DATA_W-1:0] wdata_q; // register write data

	// decode of the incoming word
	function automatic sns_op_e decode_op(input logic [SNS_INSN_W-1:0] w);
		sns_op_e r;
		r = SNS_NONE;
		if (w[13:12] == SNS_GRP_LIT && w[11:9] == SNS_OP_SUB_LIT) begin
			r = SNS_SUBLIT;
		end else if (w[13:12] == SNS_GRP_REG && w[11:8] == SNS_OP_SUB_REG) begin
			r = SNS_SUBREG;
		end else if (w[13:12] == SNS_GRP_REG && w[11:8] == SNS_OP_SWAP) begin
			r = SNS_SWAP;
		end
		return r;
	endfunction : decode_op

	// four phases, one instruction cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase_q <= SNS_PH_DECODE;
		end else begin
			unique case (phase_q)
				SNS_PH_DECODE: phase_q <= SNS_PH_READ;
				SNS_PH_READ: phase_q <= SNS_PH_PROCESS;
				SNS_PH_PROCESS: phase_q <= SNS_PH_WRITE;
				SNS_PH_WRITE: phase_q <= SNS_PH_DECODE;
			endcase
		end
	end

	// ****************************************
	// decode phase
	// ****************************************
	// latch operation fields
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			op_q <= SNS_NONE;
			dest_q <= 1'b0;
			lit_q <= 8'h00;
			addr_q <= '0;
		end else if (phase_q == SNS_PH_DECODE) begin
			op_q <= decode_op(insn);
			dest_q <= insn[SNS_DEST_BIT];
			lit_q <= insn[SNS_DATA_W-1:0];
			addr_q <= insn[SNS_ADDR_W-1:0];
		end
	end

	// ****************************************
	// read phase
	// ****************************************
	// literal or register operand
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			opnd_q <= 8'h00;
		end else if (phase_q == SNS_PH_READ) begin
			opnd_q <= (op_q == SNS_SUBLIT) ? lit_q : reg_rdata;
		end
	end

	// ****************************************
	// process phase
	// ****************************************
	logic [SNS_DATA_W-1:0] sub_diff; // subtractor result
	logic sub_c; // inverted borrow
	logic sub_dc; // nibble inverted borrow

	sns_subtractor u_sub (
		.minuend(opnd_q),
		.subtrahend(acc_q),
		.diff(sub_diff),
		.carry_no_borrow(sub_c),
		.digit_carry(sub_dc)
	);

	// compute result and candidate flags
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			res_q <= 8'h00;
			c_q <= 1'b0;
			dc_q <= 1'b0;
		end else if (phase_q == SNS_PH_PROCESS) begin
			if (op_q == SNS_SWAP) begin
				res_q <= {opnd_q[3:0], opnd_q[7:4]};
			end else begin
				res_q <= sub_diff;
			end
			c_q <= sub_c;
			dc_q <= sub_dc;
		end
	end

	// ****************************************
	// write phase
	// ****************************************
	logic is_sub; // either subtraction
	logic to_acc; // result goes to accumulator
	assign is_sub = (op_q == SNS_SUBLIT) || (op_q == SNS_SUBREG);
	assign to_acc = (op_q == SNS_SUBLIT) || (op_q != SNS_NONE && !dest_q);

	// accumulator update
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acc_q <= SNS_W_RESET;
		end else if (phase_q == SNS_PH_WRITE && to_acc) begin
			acc_q <= res_q;
		end
	end

	// flags change only on subtraction
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			c_flag_q <= 1'b0;
			dc_flag_q <= 1'b0;
			z_flag_q <= 1'b0;
		end else if (phase_q == SNS_PH_WRITE && is_sub) begin
			c_flag_q <= c_q;
			dc_flag_q <= dc_q;
			z_flag_q <= (res_q == 8'h00);
		end
	end

	// register write-back strobe, one cycle after the write phase
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			we_q <= 1'b0;
			wdata_q <= 8'h00;
		end else begin
			we_q <= phase_q == SNS_PH_WRITE && dest_q
				&& (op_q == SNS_SWAP || op_q == SNS_SUBREG);
			wdata_q <= res_q;
		end
	end

	assign reg_addr = addr_q;
	assign reg_we = we_q;
	assign reg_wdata = wdata_q;
	assign carry_flag = c_flag_q;
	assign digit_carry_flag = dc_flag_q;
	assign zero_flag = z_flag_q;
	assign cycle_start = (phase_q == SNS_PH_DECODE);

	// ****************************************
	// assertions
	// ****************************************
	// flags must not move on a swap
	swap_flags_kept_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_WRITE && op_q == SNS_SWAP |=> $stable(c_flag_q)
		&& $stable(z_flag_q) && $stable(dc_flag_q))
		else $error("swap changed a flag");
	// swapped operand lands in the accumulator
	swap_to_acc_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_READ && op_q == SNS_SWAP && !dest_q
		|=> ##2 acc_q == {$past(opnd_q[3:0], 2), $past(opnd_q[7:4], 2)})
		else $error("swap to accumulator wrong");
	swap_no_write_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_WRITE && op_q == SNS_SWAP && !dest_q |=> !we_q)
		else $error("swap wrote register with dest zero");
	// write-back data is the operand with nibbles exchanged
	swap_write_back_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_WRITE && op_q == SNS_SWAP && dest_q
		|=> we_q && $stable(acc_q)
		&& wdata_q == {$past(opnd_q[3:0]), $past(opnd_q[7:4])})
		else $error("swap write-back missing");
	phase_order_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_DECODE |=> phase_q == SNS_PH_READ
		##1 phase_q == SNS_PH_PROCESS ##1 phase_q == SNS_PH_WRITE)
		else $error("phase order broken");
	carry_set_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_PROCESS && is_sub && opnd_q >= acc_q
		|=> ##1 c_flag_q)
		else $error("carry not set without borrow");
	borrow_clear_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_PROCESS && is_sub && opnd_q < acc_q
		|=> ##1 !c_flag_q && !z_flag_q)
		else $error("borrow not shown");
	lit_result_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_PROCESS && op_q == SNS_SUBLIT
		|=> ##1 acc_q == 8'(lit_q - $past(acc_q, 2))
		&& z_flag_q == (acc_q == 8'h00))
		else $error("literal subtract wrong");
	// low nibble borrow, worked out from the operands seen in process
	digit_carry_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_PROCESS && is_sub
		|=> ##1 digit_carry_flag
		== ($past(opnd_q[3:0], 2) >= $past(acc_q[3:0], 2)))
		else $error("digit carry wrong");
	// difference goes to exactly one destination
	reg_sub_dest_a: assert property (@(posedge sys_clk)
		disable iff (rst)
		phase_q == SNS_PH_WRITE && op_q == SNS_SUBREG
		|=> we_q == dest_q && (dest_q
		? $stable(acc_q) && wdata_q == 8'($past(opnd_q) - $past(acc_q))
		: acc_q == 8'($past(opnd_q) - $past(acc_q))))
		else $error("register subtract destination wrong");
	sub_lit_c: cover property (@(posedge sys_clk) disable iff (rst)
		phase_q == SNS_PH_WRITE && op_q == SNS_SUBLIT);
	sub_reg_c: cover property (@(posedge sys_clk) disable iff (rst)
		phase_q == SNS_PH_WRITE && op_q == SNS_SUBREG && dest_q);
	swap_c: cover property (@(posedge sys_clk) disable iff (rst)
		phase_q == SNS_PH_WRITE && op_q == SNS_SWAP && !dest_q);
	borrow_c: cover property (@(posedge sys_clk) disable iff (rst)
		phase_q == SNS_PH_PROCESS && is_sub && opnd_q < acc_q);
endmodule : sns_datapath

// ### test/sns_tb.sv
// Purpose: self-checking bench for the subtract and nibble swap datapath
// Assumes: one instruction per eight clocks, results seen after edge four
// Notes: file registers are played by the bench through reg_rdata
module tb
	import sns_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// signals
	// ****************************************
	logic sys_clk = 1'b0; // core clock
	logic rst = 1'b1; // async reset
	logic [SNS_INSN_W-1:0] insn = '0; // instruction word
	logic [SNS_DATA_W-1:0] reg_rdata = '0; // file register data
	logic [SNS_ADDR_W-1:0] reg_addr; // file register address
	logic reg_we; // write strobe
	logic [SNS_DATA_W-1:0] reg_wdata; // write data
	logic [SNS_DATA_W-1:0] acc_q; // accumulator
	logic carry_flag; // inverted borrow
	logic digit_carry_flag; // low nibble inverted borrow
	logic zero_flag; // zero result
	logic cycle_start; // decode phase
	int n_mismatch = 0; // mismatches seen
	int n_checks = 0; // comparisons made
	int cyc = 0; // cycles run

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	// ****************************************
	// device under test
	// ****************************************
	sns_datapath dut_u (
		.sys_clk(sys_clk),
		.rst(rst),
		.insn(insn),
		.reg_addr(reg_addr),
		.reg_rdata(reg_rdata),
		.reg_we(reg_we),
		.reg_wdata(reg_wdata),
		.acc_q(acc_q),
		.carry_flag(carry_flag),
		.digit_carry_flag(digit_carry_flag),
		.zero_flag(zero_flag),
		.cycle_start(cycle_start)
	);

	// ****************************************
	// reporting
	// ****************************************
	// verdict and end of run
	task automatic close_out();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	// compare one value
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// flags as one byte: carry, digit carry, zero
	function automatic logic [7:0] flag_byte();
		return {5'h00, carry_flag, digit_carry_flag, zero_flag};
	endfunction : flag_byte

	// hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			close_out();
		end
	end

	// ****************************************
	// one instruction, entered at the edge before decode
	// ****************************************
	// ef holds expected write strobe, carry, digit carry, zero
	task automatic op(input logic [13:0] i, input logic [7:0] rd,
		input logic [7:0] ea, input logic [3:0] ef, input logic [7:0] ewd);
		logic [7:0] a0;
		logic [2:0] f0;
		a0 = acc_q;
		f0 = {carry_flag, digit_carry_flag, zero_flag};
		insn <= i;
		reg_rdata <= rd;
		@(posedge sys_clk);
		// garbage outside decode must be ignored
		insn <= 14'h3fff;
		#1;
		chk("addr", {1'b0, reg_addr}, {1'b0, i[6:0]});
		chk("start mid", {7'h00, cycle_start}, 8'h00);
		@(posedge sys_clk);
		// operand only held through the read phase
		reg_rdata <= ~rd;
		@(posedge sys_clk);
		#1;
		chk("acc early", acc_q, a0);
		chk("flags early", flag_byte(), {5'h00, f0});
		@(posedge sys_clk);
		insn <= 14'h0000;
		#1;
		chk("acc", acc_q, ea);
		chk("flags", flag_byte(), {5'h00, ef[2:0]});
		chk("we", {7'h00, reg_we}, {7'h00, ef[3]});
		if (ef[3]) begin
			chk("wdata", reg_wdata, ewd);
		end
		chk("start", {7'h00, cycle_start}, 8'h01);
		@(posedge sys_clk);
		#1;
		chk("we end", {7'h00, reg_we}, 8'h00);
		repeat (3) @(posedge sys_clk);
	endtask : op

	// ****************************************
	// reset in mid-run, entered at the edge before decode
	// ****************************************
	// leaves reset released at an edge, so the next edge decodes
	task automatic mid_reset();
		insn <= 14'h3cff;
		repeat (4) @(posedge sys_clk);
		insn <= 14'h0000;
		#1;
		chk("acc pre rst", acc_q, 8'hff);
		chk("flags pre rst", flag_byte(), 8'h06);
		@(posedge sys_clk);
		rst <= 1'b1;
		#1;
		chk("acc in rst", acc_q, SNS_W_RESET);
		chk("flags in rst", flag_byte(), 8'h00);
		chk("start in rst", {7'h00, cycle_start}, 8'h01);
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
	endtask : mid_reset

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (11) @(posedge sys_clk);
		#1;
		chk("rst acc", acc_q, SNS_W_RESET);
		chk("rst flags", flag_byte(), 8'h00);
		chk("rst we", {7'h00, reg_we}, 8'h00);
		@(posedge sys_clk);
		rst <= 1'b0;
		// swap to accumulator, register kept
		op(14'h0e25, 8'ha5, 8'h5a, 4'h0, 8'h00);
		// equal operands
		op(14'h3c5a, 8'h00, 8'h00, 4'h7, 8'h00);
		// swap keeps flags
		op(14'h0e00, 8'h10, 8'h01, 4'h7, 8'h00);
		// positive difference
		op(14'h3c02, 8'h00, 8'h01, 4'h6, 8'h00);
		// low nibble borrow only
		op(14'h3c10, 8'h00, 8'h0f, 4'h4, 8'h00);
		// negative difference, second literal encoding
		op(14'h3d00, 8'h00, 8'hf1, 4'h0, 8'h00);
		// swap written back, accumulator kept
		op(14'h0e91, 8'h3c, 8'hf1, 4'h8, 8'hc3);
		// register subtract to register, borrow
		op(14'h02a2, 8'h03, 8'hf1, 4'ha, 8'h12);
		// register subtract to accumulator, zero
		op(14'h0233, 8'hf1, 8'h00, 4'h7, 8'h00);
		// register subtract to register, positive
		op(14'h02b3, 8'h80, 8'h00, 4'he, 8'h80);
		// reset in mid-run, then a literal subtract from clean state
		mid_reset();
		op(14'h3c00, 8'h00, 8'h00, 4'h7, 8'h00);
		close_out();
	end
endmodule : tb
